/* File: hw/spiwm_pkg.sv */
// Package with register map, field layout and reset values for the block
// Operation
// - Rx watermark fires when level <= rx count
// - Tx watermark fires when level equals tx count
// - Levels above FIFO depth never match
// - Level bits 2 to 4 exist only for deeper FIFOs
// - Underrun with fill enabled sends fill word
// - Short words use low 16 or 8 fill bits
// - Long words use all 32 or the low 24 fill bits
// - Serial clock is bus clock over 2(divisor+1)
// - One data address: write tx, read rx
// - Mask bits 14 and 6 read zero
// - Counts report entries held in each FIFO
package spiwm_pkg;
   localparam logic [7:0]  ADDR_MASK     = 8'h00;
   localparam logic [7:0]  ADDR_FILL_LO  = 8'h04;
   localparam logic [7:0]  ADDR_FILL_HI  = 8'h08;
   localparam logic [7:0]  ADDR_BAUD     = 8'h0C;
   localparam logic [7:0]  ADDR_CTRL     = 8'h10;
   localparam logic [7:0]  ADDR_DATA     = 8'h14;
   localparam logic [7:0]  ADDR_STATUS   = 8'h18;
   localparam logic [7:0]  ADDR_IRQ_MASK = 8'h1C;
   localparam logic [7:0]  ADDR_COUNTS   = 8'h20;
   localparam int          RX_EN_BIT     = 15;
   localparam int          TX_EN_BIT     = 7;
   localparam int          RX_LVL_LSB    = 8;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_FILL_BIT = 1;
   localparam int          CTRL_WL_LSB   = 8;
   localparam logic [15:0] MASK_RESET    = 16'h0000;
   localparam logic [15:0] FILL_RESET    = 16'h0000;
   localparam logic [12:0] BAUD_RESET    = 13'h0000;
   localparam logic [2:0]  IRQ_RX_WM     = 3'h1;
   localparam logic [2:0]  IRQ_TX_WM     = 3'h2;
   localparam logic [2:0]  IRQ_UNDERRUN  = 3'h4;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

/* File: hw/spiwm_top.sv */
// Watermark interrupts, underrun fill word and baud clock of the serial unit
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module spiwm_top #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // AXI4-Lite write channels
   input  wire logic [7:0]  awaddr_in,
   input  wire logic        awvalid_in,
   output logic             awready_out,
   input  wire logic [31:0] wdata_in,
   input  wire logic [3:0]  wstrb_in,
   input  wire logic        wvalid_in,
   output logic             wready_out,
   output logic [1:0]       bresp_out,
   output logic             bvalid_out,
   input  wire logic        bready_in,
   // AXI4-Lite read channels
   input  wire logic [7:0]  araddr_in,
   input  wire logic        arvalid_in,
   output logic             arready_out,
   output logic [31:0]      rdata_out,
   output logic [1:0]       rresp_out,
   output logic             rvalid_out,
   input  wire logic        rready_in,
   // Shift engine side, same clock
   input  wire logic [5:0]  rx_fifo_count_in,
   input  wire logic [5:0]  tx_fifo_count_in,
   input  wire logic        tx_underrun_in,
   input  wire logic [31:0] receive_buffer_in,
   output logic             rx_pop_out,
   output logic [31:0]      transmit_buffer_out,
   output logic             tx_push_out,
   output logic [31:0]      tx_shift_word_out,
   output logic             unit_enable_out,
   output logic [4:0]       word_length_field_out,
   output logic             sclk_out,
   // Interrupts
   output logic             rx_watermark_out,
   output logic             tx_watermark_out,
   output logic             irq_out
);
   import spiwm_pkg::*;

   logic [15:0] fifo_watermark_mask_reg;
   logic [15:0] underrun_fill_low_reg;
   logic [15:0] underrun_fill_high_reg;
   logic [12:0] baud_divisor_reg;
   logic        unit_enable_reg;
   logic        underrun_fill_enable_reg;
   logic [4:0]  word_length_field_reg;
   logic [2:0]  irq_status_reg;
   logic [2:0]  irq_mask_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [12:0] baud_cnt_reg;

   // Implemented level bits depend on depth
   localparam logic [5:0] LVL_IMPL =
      (FIFO_DEPTH >= 32) ? 6'h3F : (FIFO_DEPTH >= 16) ? 6'h2F :
      (FIFO_DEPTH >= 8) ? 6'h27 : 6'h23;
   localparam logic [15:0] MASK_WR =
      {1'b1, 1'b0, LVL_IMPL, 1'b1, 1'b0, LVL_IMPL};
   localparam logic [6:0] DEPTH_W = 7'(FIFO_DEPTH);

   // A level is usable only within depth
   function automatic logic lvl_ok(input logic [5:0] lvl);
      return {1'b0, lvl} <= DEPTH_W;
   endfunction

   wire [5:0] rx_watermark_level = fifo_watermark_mask_reg[RX_LVL_LSB +: 6];
   wire [5:0] tx_watermark_level = fifo_watermark_mask_reg[5:0];
   wire rx_watermark_irq_enable = fifo_watermark_mask_reg[RX_EN_BIT];
   wire tx_watermark_irq_enable = fifo_watermark_mask_reg[TX_EN_BIT];

   // Watermark conditions, combinational each cycle
   wire rx_wm_hit = rx_watermark_irq_enable && lvl_ok(rx_watermark_level)
                    && (rx_watermark_level <= rx_fifo_count_in);
   wire tx_wm_hit = tx_watermark_irq_enable && lvl_ok(tx_watermark_level)
                    && (tx_watermark_level == tx_fifo_count_in);

   // Fill word selection by word length (0 means 32 bits)
   wire [5:0] wl_bits = (word_length_field_reg == 5'h00) ? 6'h20 :
                        {1'b0, word_length_field_reg};
   wire [31:0] fill_full = {underrun_fill_high_reg, underrun_fill_low_reg};
   wire [31:0] fill_sel =
      (wl_bits >= 6'h19) ? fill_full :
      (wl_bits >= 6'h11) ? {8'h00, fill_full[23:0]} :
      (wl_bits >= 6'h09) ? {16'h0000, fill_full[15:0]} :
                           {24'h000000, fill_full[7:0]};

   // Bus handshake decode
   wire aw_take = awvalid_in && !aw_held_reg && !bvalid_out;
   wire w_take = wvalid_in && !w_held_reg && !bvalid_out;
   wire aw_have = aw_held_reg || aw_take;
   wire w_have = w_held_reg || w_take;
   wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : awaddr_in;
   wire [31:0] wr_data = w_held_reg ? w_data_reg : wdata_in;
   wire wr_fire = aw_have && w_have && !bvalid_out;
   wire rd_fire = arvalid_in && !rvalid_out;
   // Next handshake state, so every ready output comes from a flop
   wire aw_held_next = aw_have && !wr_fire;
   wire w_held_next = w_have && !wr_fire;
   wire bvalid_next = wr_fire || (bvalid_out && !bready_in);
   wire rvalid_next = rd_fire || (rvalid_out && !rready_in);
   wire wr_known = (wr_addr <= ADDR_COUNTS) && (wr_addr[1:0] == 2'h0);
   wire rd_known = (araddr_in <= ADDR_COUNTS) && (araddr_in[1:0] == 2'h0);
   wire wr_mask = wr_fire && wr_addr == ADDR_MASK;
   wire wr_flo = wr_fire && wr_addr == ADDR_FILL_LO;
   wire wr_fhi = wr_fire && wr_addr == ADDR_FILL_HI;
   wire wr_baud = wr_fire && wr_addr == ADDR_BAUD;
   wire wr_ctrl = wr_fire && wr_addr == ADDR_CTRL;
   wire wr_data_port = wr_fire && wr_addr == ADDR_DATA;
   wire wr_imask = wr_fire && wr_addr == ADDR_IRQ_MASK;
   wire rd_status = rd_fire && araddr_in == ADDR_STATUS;
   wire rd_data_port = rd_fire && araddr_in == ADDR_DATA;

   // Read mux
   wire [31:0] rd_word =
      (araddr_in == ADDR_MASK) ? {16'h0000, fifo_watermark_mask_reg} :
      (araddr_in == ADDR_FILL_LO) ? {16'h0000, underrun_fill_low_reg} :
      (araddr_in == ADDR_FILL_HI) ? {16'h0000, underrun_fill_high_reg} :
      (araddr_in == ADDR_BAUD) ? {19'h00000, baud_divisor_reg} :
      (araddr_in == ADDR_CTRL) ? {19'h00000, word_length_field_reg,
                                  6'h00, underrun_fill_enable_reg,
                                  unit_enable_reg} :
      (araddr_in == ADDR_DATA) ? receive_buffer_in :
      (araddr_in == ADDR_STATUS) ? {29'h0, irq_status_reg} :
      (araddr_in == ADDR_IRQ_MASK) ? {29'h0, irq_mask_reg} :
      (araddr_in == ADDR_COUNTS) ? {18'h0, rx_fifo_count_in, 2'h0,
                                    tx_fifo_count_in} : 32'h0;

   // Sticky events: set wins over read clear
   wire [2:0] ev = {tx_underrun_in, tx_wm_hit, rx_wm_hit};
   wire [2:0] irq_status_next = (rd_status ? 3'h0 : irq_status_reg) | ev;

   // Baud divider toggles sclk every divisor+1 cycles
   wire baud_wrap = baud_cnt_reg >= baud_divisor_reg;

   // Write channel capture
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0;
         bvalid_out <= 1'b0;
         bresp_out <= RESP_OKAY;
         awready_out <= 1'b1;
         wready_out <= 1'b1;
      end else begin
         if (aw_take) aw_addr_reg <= awaddr_in;
         if (w_take) w_data_reg <= wdata_in;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_out <= !aw_held_next && !bvalid_next;
         wready_out <= !w_held_next && !bvalid_next;
         if (wr_fire) begin
            bvalid_out <= 1'b1;
            bresp_out <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (bready_in) begin
            bvalid_out <= 1'b0;
         end
      end
   end

   // Read channel
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rvalid_out <= 1'b0;
         rdata_out <= 32'h0;
         rresp_out <= RESP_OKAY;
         rx_pop_out <= 1'b0;
         arready_out <= 1'b1;
      end else begin
         rx_pop_out <= rd_data_port;
         arready_out <= !rvalid_next;
         if (rd_fire) begin
            rvalid_out <= 1'b1;
            rdata_out <= rd_word;
            rresp_out <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (rready_in) begin
            rvalid_out <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         fifo_watermark_mask_reg <= MASK_RESET;
         underrun_fill_low_reg <= FILL_RESET;
         underrun_fill_high_reg <= FILL_RESET;
         baud_divisor_reg <= BAUD_RESET;
         unit_enable_reg <= 1'b0;
         underrun_fill_enable_reg <= 1'b0;
         word_length_field_reg <= 5'h00;
         irq_mask_reg <= 3'h0;
      end else begin
         if (wr_mask) fifo_watermark_mask_reg <= wr_data[15:0] & MASK_WR;
         if (wr_flo) underrun_fill_low_reg <= wr_data[15:0];
         if (wr_fhi) underrun_fill_high_reg <= wr_data[15:0];
         // Ignored while enabled so the divider cannot glitch
         if (wr_baud && !unit_enable_reg)
            baud_divisor_reg <= wr_data[12:0];
         if (wr_ctrl) begin
            unit_enable_reg <= wr_data[CTRL_EN_BIT];
            underrun_fill_enable_reg <= wr_data[CTRL_FILL_BIT];
            word_length_field_reg <= wr_data[CTRL_WL_LSB +: 5];
         end
         if (wr_imask) irq_mask_reg <= wr_data[2:0];
      end
   end

   // Transmit path, watermark events and interrupt
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         tx_push_out <= 1'b0;
         transmit_buffer_out <= 32'h0;
         tx_shift_word_out <= 32'h0;
         irq_status_reg <= 3'h0;
         rx_watermark_out <= 1'b0;
         tx_watermark_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         tx_push_out <= wr_data_port;
         if (wr_data_port) transmit_buffer_out <= wr_data;
         tx_shift_word_out <= (underrun_fill_enable_reg && tx_underrun_in)
                              ? fill_sel : 32'h0;
         irq_status_reg <= irq_status_next;
         rx_watermark_out <= rx_wm_hit;
         tx_watermark_out <= tx_wm_hit;
         irq_out <= |(irq_status_next & irq_mask_reg);
      end
   end

   // Serial clock generator
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         baud_cnt_reg <= 13'h0000;
         sclk_out <= 1'b0;
      end else if (!unit_enable_reg) begin
         baud_cnt_reg <= 13'h0000;
         sclk_out <= 1'b0;
      end else begin
         baud_cnt_reg <= baud_wrap ? 13'h0000 : baud_cnt_reg + 13'h0001;
         if (baud_wrap) sclk_out <= !sclk_out;
      end
   end

   always_comb begin
      unit_enable_out = unit_enable_reg;
      word_length_field_out = word_length_field_reg;
   end

   // Watermark checks
   a_rx_wm_level: assert property (@(posedge clock_in)
      disable iff (rst_in) rx_wm_hit |=> rx_watermark_out)
      else $error("rx watermark not raised");

   a_rx_wm_off: assert property (@(posedge clock_in)
      disable iff (rst_in) !rx_watermark_irq_enable |=> !rx_watermark_out)
      else $error("rx watermark while disabled");

   a_tx_wm_fire: assert property (@(posedge clock_in)
      disable iff (rst_in) tx_wm_hit |=> tx_watermark_out)
      else $error("tx watermark not raised");

   a_tx_wm_equal: assert property (@(posedge clock_in)
      disable iff (rst_in) tx_watermark_out |->
      $past(tx_watermark_level == tx_fifo_count_in
      && tx_watermark_irq_enable))
      else $error("tx watermark without match");

   a_invalid_lvl: assert property (@(posedge clock_in)
      disable iff (rst_in)
      rx_watermark_out |-> $past(lvl_ok(rx_watermark_level)))
      else $error("watermark on invalid level");

   a_tx_invalid: assert property (@(posedge clock_in)
      disable iff (rst_in)
      tx_watermark_out |-> $past(lvl_ok(tx_watermark_level)))
      else $error("tx watermark on invalid level");

   a_impl_bits: assert property (@(posedge clock_in)
      disable iff (rst_in)
      (fifo_watermark_mask_reg & ~MASK_WR) == 16'h0000)
      else $error("unimplemented mask bit set");

   a_wm_hold: assert property (@(posedge clock_in)
      disable iff (rst_in) rx_wm_hit [*2] |=> rx_watermark_out)
      else $error("watermark not held");

   // Fill word checks: one with fill off, then one per word length band
   a_fill_off: assert property (@(posedge clock_in)
      disable iff (rst_in) !(underrun_fill_enable_reg && tx_underrun_in)
      |=> tx_shift_word_out == 32'h0)
      else $error("fill word sent without underrun");

   a_fill_send: assert property (@(posedge clock_in)
      disable iff (rst_in)
      (underrun_fill_enable_reg && tx_underrun_in && wl_bits <= 6'h08)
      |=> tx_shift_word_out == {24'h0, $past(underrun_fill_low_reg[7:0])})
      else $error("fill word width wrong");

   a_fill_mid: assert property (@(posedge clock_in)
      disable iff (rst_in)
      (underrun_fill_enable_reg && tx_underrun_in && wl_bits >= 6'h09
      && wl_bits <= 6'h10)
      |=> tx_shift_word_out == {16'h0, $past(underrun_fill_low_reg)})
      else $error("16-bit fill word wrong");

   a_fill_24: assert property (@(posedge clock_in)
      disable iff (rst_in)
      (underrun_fill_enable_reg && tx_underrun_in && wl_bits >= 6'h11
      && wl_bits <= 6'h18)
      |=> tx_shift_word_out == {8'h0, $past(fill_full[23:0])})
      else $error("24-bit fill word wrong");

   a_fill_long: assert property (@(posedge clock_in)
      disable iff (rst_in)
      (underrun_fill_enable_reg && tx_underrun_in && wl_bits >= 6'h19)
      |=> tx_shift_word_out == $past(fill_full))
      else $error("full fill word not sent");

   // Data port, bus and serial clock checks
   a_data_push: assert property (@(posedge clock_in)
      disable iff (rst_in) wr_data_port |=> tx_push_out
      && transmit_buffer_out == $past(wr_data))
      else $error("data write not pushed");

   a_pop_data: assert property (@(posedge clock_in)
      disable iff (rst_in) rd_data_port |=> rx_pop_out)
      else $error("data read not popped");

   a_ready_busy: assert property (@(posedge clock_in)
      disable iff (rst_in) bvalid_out |-> !awready_out && !wready_out)
      else $error("write ready while response pending");

   a_rvalid_hold: assert property (@(posedge clock_in)
      disable iff (rst_in) (rvalid_out && !rready_in)
      |=> rvalid_out && $stable(rdata_out))
      else $error("read data dropped before taken");

   a_baud_hold: assert property (@(posedge clock_in)
      disable iff (rst_in) (unit_enable_reg && $changed(sclk_out))
      |=> !$changed(sclk_out) || baud_divisor_reg == 13'h0000)
      else $error("sclk toggles too fast");

   a_sclk_idle: assert property (@(posedge clock_in)
      disable iff (rst_in) !unit_enable_reg |=> !sclk_out)
      else $error("sclk runs while disabled");
endmodule

/* File: bench/spiwm_far_model.sv */
// Behavioural shift-engine side: FIFO counts, underrun and inverted echo data
`timescale 1ns/1ps
module spiwm_far_model (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // Bench commands
   input  wire logic        load_in,
   input  wire logic [5:0]  rx_set_in,
   input  wire logic [5:0]  tx_set_in,
   input  wire logic        underrun_set_in,
   // Design side
   input  wire logic        rx_pop_in,
   input  wire logic        tx_push_in,
   input  wire logic [31:0] tx_word_in,
   output logic [5:0]       rx_count_out,
   output logic [5:0]       tx_count_out,
   output logic             underrun_out,
   output logic [31:0]      rx_word_out
);
   // Each push is a full exchange, so one word also lands on receive
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rx_count_out <= 6'h00;
         tx_count_out <= 6'h00;
         underrun_out <= 1'b0;
         rx_word_out  <= 32'hFFFFFFFF;
      end else if (load_in) begin
         rx_count_out <= rx_set_in;
         tx_count_out <= tx_set_in;
      end else begin
         rx_count_out <= rx_count_out + 6'(tx_push_in) - 6'(rx_pop_in);
         tx_count_out <= tx_count_out + 6'(tx_push_in);
         underrun_out <= underrun_set_in;
         if (tx_push_in) rx_word_out <= ~tx_word_in;
      end
   end
endmodule

/* File: bench/spiwm_top_test.sv */
// Register-level test of watermark, fill word and baud logic
`timescale 1ns/1ps
module spiwm_top_test;
   import spiwm_pkg::*;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, pop, push;
   logic        uen, sclk, rxwm, txwm, irq, und, load, und_set;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, tbuf, shw, rxw, rd;
   logic [1:0]  bresp, rresp, rs;
   logic [4:0]  wl;
   logic [5:0]  rxc, txc, rx_set, tx_set;
   int          err_count, checks_done;
   realtime     t0;
   // Watermark cases: mask, rx count, tx count, expected {rx, tx}
   logic [15:0] wmm [6] = '{16'h8383, 16'h8383, 16'h8383, 16'h0303,
                            16'hA0A0, 16'h8080};
   logic [5:0]  wrx [6] = '{6'h02, 6'h03, 6'h05, 6'h05, 6'h20, 6'h00};
   logic [5:0]  wtx [6] = '{6'h03, 6'h04, 6'h02, 6'h03, 6'h20, 6'h00};
   logic [1:0]  wex [6] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h3};
   // Word lengths and the fill bits each one keeps
   logic [4:0]  flw [8] = '{5'h00, 5'h19, 5'h18, 5'h11, 5'h10, 5'h09,
                            5'h08, 5'h02};
   logic [31:0] flm [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00FFFFFF,
                            32'h00FFFFFF, 32'h0000FFFF, 32'h0000FFFF,
                            32'h000000FF, 32'h000000FF};
   logic [12:0] bdv [2] = '{13'h0000, 13'h0002};

   spiwm_top #(.FIFO_DEPTH(8)) dut (
      .clock_in(clk), .rst_in(rst), .awaddr_in(awaddr),
      .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
      .wstrb_in(4'hF), .wvalid_in(wvalid), .wready_out(wready),
      .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
      .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
      .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
      .rready_in(rready), .rx_fifo_count_in(rxc), .tx_fifo_count_in(txc),
      .tx_underrun_in(und), .receive_buffer_in(rxw), .rx_pop_out(pop),
      .transmit_buffer_out(tbuf), .tx_push_out(push),
      .tx_shift_word_out(shw), .unit_enable_out(uen),
      .word_length_field_out(wl), .sclk_out(sclk),
      .rx_watermark_out(rxwm), .tx_watermark_out(txwm), .irq_out(irq));

   spiwm_far_model far (
      .clock_in(clk), .rst_in(rst), .load_in(load), .rx_set_in(rx_set),
      .tx_set_in(tx_set), .underrun_set_in(und_set), .rx_pop_in(pop),
      .tx_push_in(push), .tx_word_in(tbuf), .rx_count_out(rxc),
      .tx_count_out(txc), .underrun_out(und), .rx_word_out(rxw));

   // Free-running bus clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask

   // Write: each channel held until taken, then wait for the response
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 99);
      if (bvalid !== 1'b1) begin
         err_count++;
         $display("ERROR %0t write response timed out", $time);
      end
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 99);
      if (rvalid !== 1'b1) begin
         err_count++;
         $display("ERROR %0t read response timed out", $time);
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rdr(a);
      chk(rd, e);
   endtask

   // Let two edges land so registered outputs have caught up
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic ld(input logic [5:0] r, input logic [5:0] t);
      @(posedge clk);
      rx_set <= r;
      tx_set <= t;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      settle();
   endtask

   task automatic close_out();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #400000;
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      close_out();
   end

   // Main sequence
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata, load, und_set} = 50'h0;
      {rx_set, tx_set} = 12'h000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rc(ADDR_MASK, 32'h0);
      rc(ADDR_FILL_LO, 32'h0);
      rc(ADDR_FILL_HI, 32'h0);
      wr(ADDR_MASK, 32'hFFFF);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      rc(ADDR_MASK, 32'h0000A7A7);
      foreach (wmm[i]) begin
         wr(ADDR_MASK, {16'h0, wmm[i]});
         ld(wrx[i], wtx[i]);
         chk({30'h0, rxwm, txwm}, {30'h0, wex[i]});
      end
      // Interrupt: masked, unmasked, then cleared by a status read
      wr(ADDR_MASK, 32'h8383);
      ld(6'h03, 6'h00);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_MASK, {29'h0, IRQ_RX_WM});
      settle();
      chk({31'h0, irq}, 32'h1);
      wr(ADDR_MASK, 32'h0);
      rdr(ADDR_STATUS);
      chk({31'h0, rd[0]}, 32'h1);
      rc(ADDR_STATUS, 32'h0);
      settle();
      chk({31'h0, irq}, 32'h0);
      // Divisor only changed while the unit is off
      foreach (bdv[i]) begin
         wr(ADDR_CTRL, 32'h0);
         wr(ADDR_BAUD, {19'h0, bdv[i]});
         rc(ADDR_BAUD, {19'h0, bdv[i]});
         wr(ADDR_CTRL, 32'h1);
         @(posedge sclk);
         t0 = $realtime;
         @(posedge sclk);
         chk(32'(int'(($realtime - t0) / 20.0)),
             ({19'h0, bdv[i]} + 32'h1) * 32'h2);
      end
      wr(ADDR_BAUD, 32'h7);
      rc(ADDR_BAUD, 32'h2);
      // Fill word under underrun, trimmed by word length
      wr(ADDR_FILL_LO, 32'h0000ABCD);
      wr(ADDR_FILL_HI, 32'h00001234);
      und_set <= 1'b1;
      foreach (flw[i]) begin
         wr(ADDR_CTRL, {19'h0, flw[i], 8'h03});
         settle();
         chk(shw, 32'h1234ABCD & flm[i]);
         chk({26'h0, uen, wl}, {26'h0, 1'b1, flw[i]});
      end
      wr(ADDR_CTRL, 32'h1);
      settle();
      chk(shw, 32'h0);
      rdr(ADDR_STATUS);
      chk({31'h0, rd[2]}, 32'h1);
      und_set <= 1'b0;
      // One data address: write pushes, read returns the exchange
      ld(6'h03, 6'h04);
      wr(ADDR_DATA, 32'hCAFE0001);
      chk(tbuf, 32'hCAFE0001);
      settle();
      rc(ADDR_DATA, 32'h3501FFFE);
      settle();
      rc(ADDR_COUNTS, 32'h00000305);
      // Unmapped address is refused
      wr(8'h40, 32'h1);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      rc(8'h40, 32'h0);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      close_out();
   end
endmodule
